// [logic/ubu_pkg.sv]
package ubu_pkg;

    // ---------------------------------------------------------------
    // Register byte addresses
    // ---------------------------------------------------------------
    localparam logic [31:0] ADDR_BREAK_CONTROL  = 32'hffffff78;
    localparam logic [31:0] ADDR_CYCLE_SELECT_B = 32'hffffff68;
    localparam logic [31:0] ADDR_CYCLE_SELECT_A = 32'hffffff48;
    localparam logic [31:0] ADDR_ADDRESS_A      = 32'hffffff40;
    localparam logic [31:0] ADDR_ADDRESS_MASK_A = 32'hffffff44;
    localparam logic [31:0] ADDR_ADDRESS_B      = 32'hffffff60;
    localparam logic [31:0] ADDR_ADDRESS_MASK_B = 32'hffffff64;
    localparam logic [31:0] ADDR_DATA_B         = 32'hffffff70;
    localparam logic [31:0] ADDR_DATA_MASK_B    = 32'hffffff74;

    // ---------------------------------------------------------------
    // Break control fields
    // ---------------------------------------------------------------
    localparam int BIT_CORE_FLAG_A   = 15;
    localparam int BIT_PERIPH_FLAG_A = 14;
    localparam int BIT_EXT_BREAK_EN  = 13;
    localparam int BIT_MODE          = 12;
    localparam int BIT_TIMING_A      = 10;
    localparam int BIT_CORE_FLAG_B   = 7;
    localparam int BIT_PERIPH_FLAG_B = 6;
    localparam int BIT_CHAIN         = 4;
    localparam int BIT_DATA_CMP_B    = 3;
    localparam int BIT_TIMING_B      = 2;
    localparam logic [15:0] CTRL_WR_MASK  = 16'h341c;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;

    // ---------------------------------------------------------------
    // Cycle select fields
    // ---------------------------------------------------------------
    localparam int SEL_CLASS_LSB = 6;
    localparam int SEL_FETCH_LSB = 4;
    localparam int SEL_RW_LSB    = 2;
    localparam int SEL_SIZE_LSB  = 0;
    localparam logic [15:0] SEL_WR_MASK = 16'h00ff;
    localparam logic [15:0] SEL_RESET   = 16'h0000;
    localparam logic [1:0]  SIZE_ANY    = 2'h0;

    // ---------------------------------------------------------------
    // AHB codes
    // ---------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    // One observed bus cycle; size 1 byte, 2 word, 3 longword
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [31:0] data;
        logic        periph;
        logic        fetch;
        logic        write;
        logic [1:0]  size;
        logic        external;
    } ubu_cycle_t;

endpackage

// [logic/ubu_break_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// (R01) Class field: none, core, periph, both
// (R02) Fetch/data field: none, fetch, data, both
// (R03) Read/write field: none, read, write, both
// (R04) Size field: ignore, byte, word, longword
// (R05) Channel A core match sets flag, interrupts
// (R06) Channel A periph match sets flag, interrupts
// (R07) External cycles break only when enabled
// (R08) Mode bit: compatible at 0, extended at 1
// (R09) Channel A fetch break before/after execution
// (R10) Channel B core match sets flag, interrupts
// (R11) Channel B periph match sets flag, interrupts
// (R12) Chaining: channel B only after channel A
// (R13) Data compare on channel B when enabled
// (R14) Channel B fetch break before/after execution
// (R15) Address mask B bits drop address bits
// (R16) Data mask B bits drop data bits
// (R17) Match needs every enabled qualifier true
// (R18) Software clears flags by writing zero
module ubu_break_ctrl (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire ubu_pkg::ubu_cycle_t cyc,
    output logic                   user_break_irq,
    output logic                   break_req,
    output logic                   break_after_exec
);
    import ubu_pkg::*;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Two-bit select: bit0 takes the "low" kind, bit1 the "high"
    function automatic logic sel2(input logic [1:0] f, input logic hi);
        return (f[0] & ~hi) | (f[1] & hi);
    endfunction

    // Masked compare: a set mask bit drops that bit
    function automatic logic mcmp(input logic [31:0] a, input logic [31:0] b,
                                  input logic [31:0] m);
        return ((a ^ b) & ~m) == 32'h0000_0000;
    endfunction

    // Qualify class, access kind, direction and size
    function automatic logic qual(input logic [15:0] s, input ubu_cycle_t c);
        logic sz_ok;
        sz_ok = (s[SEL_SIZE_LSB +: 2] == SIZE_ANY) |
                (s[SEL_SIZE_LSB +: 2] == c.size);
        return sel2(s[SEL_CLASS_LSB +: 2], c.periph) &
               sel2(s[SEL_FETCH_LSB +: 2], ~c.fetch) &
               sel2(s[SEL_RW_LSB +: 2], c.write) & sz_ok;
    endfunction

    // ---------------------------------------------------------------
    // AHB-Lite slave
    // ---------------------------------------------------------------
    logic        dph_q;
    logic        dph_wr_q;
    logic [31:0] dph_addr_q;
    logic        take;
    logic        wr;

    assign take      = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign wr        = dph_q & dph_wr_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q      <= 1'b0;
            dph_wr_q   <= 1'b0;
            dph_addr_q <= 32'h0000_0000;
        end else if (hready) begin
            dph_q      <= take;
            dph_wr_q   <= hwrite;
            dph_addr_q <= haddr;
        end
    end

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    logic [15:0] sel_a_q;
    logic [15:0] sel_b_q;
    logic [31:0] addr_a_q;
    logic [31:0] amask_a_q;
    logic [31:0] addr_b_q;
    logic [31:0] amask_b_q;
    logic [31:0] data_b_q;
    logic [31:0] dmask_b_q;
    logic [15:0] ctl_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_a_q   <= SEL_RESET;
            sel_b_q   <= SEL_RESET;
            addr_a_q  <= 32'h0000_0000;
            amask_a_q <= 32'h0000_0000;
            addr_b_q  <= 32'h0000_0000;
            amask_b_q <= 32'h0000_0000;
            data_b_q  <= 32'h0000_0000;
            dmask_b_q <= 32'h0000_0000;
        end else if (wr) begin
            case (dph_addr_q)
                ADDR_CYCLE_SELECT_A: sel_a_q   <= hwdata[15:0] & SEL_WR_MASK;
                ADDR_CYCLE_SELECT_B: sel_b_q   <= hwdata[15:0] & SEL_WR_MASK;
                ADDR_ADDRESS_A:      addr_a_q  <= hwdata;
                ADDR_ADDRESS_MASK_A: amask_a_q <= hwdata;
                ADDR_ADDRESS_B:      addr_b_q  <= hwdata;
                ADDR_ADDRESS_MASK_B: amask_b_q <= hwdata;
                ADDR_DATA_B:         data_b_q  <= hwdata;
                ADDR_DATA_MASK_B:    dmask_b_q <= hwdata;
                default: begin
                end
            endcase
        end
    end

    // Control bits only; flags live in their own process
    logic ctl_wr;
    assign ctl_wr = wr & (dph_addr_q == ADDR_BREAK_CONTROL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_q <= CTRL_RESET;
        end else if (ctl_wr) begin
            ctl_q <= hwdata[15:0] & CTRL_WR_MASK;
        end
    end

    logic ext_en;
    logic ext_mode;
    logic chain_eff;
    logic dcmp_eff;

    // (R07) external cycle gate
    assign ext_en   = ctl_q[BIT_EXT_BREAK_EN];
    // (R08) compatible mode drops extended features
    assign ext_mode = ctl_q[BIT_MODE];
    // Chaining and data compare exist only in extended mode
    assign chain_eff = ext_mode & ctl_q[BIT_CHAIN];
    assign dcmp_eff  = ext_mode & ctl_q[BIT_DATA_CMP_B];

    // ---------------------------------------------------------------
    // Match logic
    // ---------------------------------------------------------------
    logic ext_ok;
    logic hit_a;
    logic hit_b;
    logic armed_q;

    // (R07) external cycles need the enable
    assign ext_ok = cyc.valid & (~cyc.external | ext_en);

    // (R01) (R02) (R03) (R04) (R15) (R17) all qualifiers
    assign hit_a = ext_ok & qual(sel_a_q, cyc) &
                   mcmp(cyc.addr, addr_a_q, amask_a_q);

    // (R12) (R13) (R16) chain gate and data compare
    assign hit_b = ext_ok & qual(sel_b_q, cyc) &
                   mcmp(cyc.addr, addr_b_q, amask_b_q) &
                   (~dcmp_eff | mcmp(cyc.data, data_b_q, dmask_b_q)) &
                   (~chain_eff | armed_q);

    // (R12) channel A arms channel B
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_q <= 1'b0;
        end else if (!chain_eff || hit_b) begin
            armed_q <= 1'b0;
        end else if (hit_a) begin
            armed_q <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Match flags
    // ---------------------------------------------------------------
    logic [3:0] flag_q;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;

    // Order: core A, periph A, core B, periph B
    assign flag_set = {hit_a & ~cyc.periph, hit_a & cyc.periph,
                       hit_b & ~cyc.periph, hit_b & cyc.periph};
    assign flag_clr = {4{ctl_wr}} &
                      ~{hwdata[BIT_CORE_FLAG_A], hwdata[BIT_PERIPH_FLAG_A],
                        hwdata[BIT_CORE_FLAG_B], hwdata[BIT_PERIPH_FLAG_B]};

    // (R05) (R06) (R10) (R11) (R18) set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= 4'h0;
        end else begin
            flag_q <= flag_set | (flag_q & ~flag_clr);
        end
    end

    // Level request; stays up until software clears all flags
    assign user_break_irq = |flag_q;

    // ---------------------------------------------------------------
    // Break request and fetch timing
    // ---------------------------------------------------------------
    // (R09) (R14) channel A timing wins on a shared fetch hit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            break_req        <= 1'b0;
            break_after_exec <= 1'b0;
        end else begin
            break_req <= hit_a | hit_b;
            if (hit_a && cyc.fetch) begin
                break_after_exec <= ctl_q[BIT_TIMING_A];
            end else if (hit_b && cyc.fetch) begin
                break_after_exec <= ctl_q[BIT_TIMING_B];
            end else if (hit_a || hit_b) begin
                break_after_exec <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    // Reads in the data phase see stored flops, so a read right after
    // a write to the same register already shows the new value
    logic [15:0] ctl_view;
    always_comb begin
        ctl_view = ctl_q;
        ctl_view[BIT_CORE_FLAG_A]   = flag_q[3];
        ctl_view[BIT_PERIPH_FLAG_A] = flag_q[2];
        ctl_view[BIT_CORE_FLAG_B]   = flag_q[1];
        ctl_view[BIT_PERIPH_FLAG_B] = flag_q[0];
        hrdata = 32'h0000_0000;
        if (dph_q && !dph_wr_q) begin
            case (dph_addr_q)
                ADDR_BREAK_CONTROL:  hrdata = {16'h0000, ctl_view};
                ADDR_CYCLE_SELECT_A: hrdata = {16'h0000, sel_a_q};
                ADDR_CYCLE_SELECT_B: hrdata = {16'h0000, sel_b_q};
                ADDR_ADDRESS_A:      hrdata = addr_a_q;
                ADDR_ADDRESS_MASK_A: hrdata = amask_a_q;
                ADDR_ADDRESS_B:      hrdata = addr_b_q;
                ADDR_ADDRESS_MASK_B: hrdata = amask_b_q;
                ADDR_DATA_B:         hrdata = data_b_q;
                ADDR_DATA_MASK_B:    hrdata = dmask_b_q;
                default:             hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_class_none: assert property ( // (R01)
        (sel_b_q[SEL_CLASS_LSB +: 2] == 2'h0) |-> !hit_b)
        else $error("channel B hit with class field zero");

    a_fetch_sel: assert property ( // (R02)
        (cyc.valid && sel_b_q[SEL_FETCH_LSB +: 2] == 2'h1 && !cyc.fetch)
        |-> !hit_b)
        else $error("channel B hit on data cycle in fetch-only mode");

    a_rw_sel: assert property ( // (R03)
        (sel_b_q[SEL_RW_LSB +: 2] == 2'h1 && cyc.write) |-> !hit_b)
        else $error("channel B hit on write in read-only mode");

    a_size_sel: assert property ( // (R04)
        (sel_b_q[SEL_SIZE_LSB +: 2] != 2'h0 &&
         sel_b_q[SEL_SIZE_LSB +: 2] != cyc.size) |-> !hit_b)
        else $error("channel B hit on wrong size");

    a_core_flag_a: assert property ( // (R05)
        (hit_a && !cyc.periph) |=> flag_q[3] && user_break_irq)
        else $error("core flag A not set after match");

    a_periph_flag_a: assert property ( // (R06)
        (hit_a && cyc.periph) |=> flag_q[2] && user_break_irq)
        else $error("periph flag A not set after match");

    a_ext_gate: assert property ( // (R07)
        (cyc.external && !ext_en) |-> !hit_a && !hit_b)
        else $error("external cycle matched while disabled");

    a_compat_mode: assert property ( // (R08)
        (!ctl_q[BIT_MODE] && ext_ok && qual(sel_b_q, cyc) &&
         mcmp(cyc.addr, addr_b_q, amask_b_q)) |-> hit_b)
        else $error("channel B blocked by extended feature in compatible mode");

    a_timing_a: assert property ( // (R09)
        (hit_a && cyc.fetch) |=> break_req &&
        break_after_exec == $past(ctl_q[BIT_TIMING_A]))
        else $error("channel A fetch timing wrong");

    a_core_flag_b: assert property ( // (R10)
        (hit_b && !cyc.periph) |=> flag_q[1])
        else $error("core flag B not set after match");

    a_periph_flag_b: assert property ( // (R11)
        (hit_b && cyc.periph) |=> flag_q[0])
        else $error("periph flag B not set after match");

    a_chain_gate: assert property ( // (R12)
        (chain_eff && !armed_q) |-> !hit_b)
        else $error("channel B matched before channel A");

    a_data_cmp: assert property ( // (R13)
        (dcmp_eff && !mcmp(cyc.data, data_b_q, dmask_b_q)) |-> !hit_b)
        else $error("channel B hit despite data mismatch");

    a_timing_b: assert property ( // (R14)
        (hit_b && cyc.fetch && !hit_a) |=>
        break_after_exec == $past(ctl_q[BIT_TIMING_B]))
        else $error("channel B fetch timing wrong");

    a_addr_mask_b: assert property ( // (R15)
        !mcmp(cyc.addr, addr_b_q, amask_b_q) |-> !hit_b)
        else $error("channel B hit despite address mismatch");

    a_flag_hold: assert property ( // (R18)
        (flag_q[3] && !ctl_wr) |=> flag_q[3])
        else $error("core flag A dropped without a clearing write");

    c_chain_hit: cover property (chain_eff && armed_q && hit_b);
    c_data_hit:  cover property (dcmp_eff && hit_b);
    c_set_clear: cover property (flag_set[3] && flag_clr[3]);
endmodule
`default_nettype wire

// [sim/ubu_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------
// Core and peripheral bus cycle source
// ---------------------------------------------
module ubu_core_model (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                send,
    input  wire ubu_pkg::ubu_cycle_t nxt,
    output var  ubu_pkg::ubu_cycle_t cyc
);
    import ubu_pkg::*;

    // One cycle per send; idle lines toggle so stale values never match
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc <= '0;
        end else if (send) begin
            cyc       <= nxt;
            cyc.valid <= 1'b1;
        end else begin
            cyc.valid <= 1'b0;
            cyc.addr  <= ~cyc.addr;
            cyc.data  <= ~cyc.data;
        end
    end
endmodule
`default_nettype wire

// [sim/user_break_condition_control_test.sv]
`timescale 1ns/10ps
`default_nettype none
module user_break_condition_control_test;
    import ubu_pkg::*;
    logic        hclk;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic        send    = 1'b0;
    logic [1:0]  htrans  = 2'h0;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    ubu_cycle_t  nxt     = '0;
    ubu_cycle_t  cyc;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, user_break_irq, break_req, break_after_exec;
    wire  logic  hready;
    int          errors      = 0;
    int          comparisons = 0;

    assign hready = hreadyout;

    ubu_break_ctrl u_ubu_break_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .cyc(cyc), .user_break_irq(user_break_irq),
        .break_req(break_req), .break_after_exec(break_after_exec));

    ubu_core_model u_ubu_core_model (
        .hclk(hclk), .hresetn(hresetn), .send(send), .nxt(nxt), .cyc(cyc));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ---------------------------------------------
    // Shared tasks
    // ---------------------------------------------
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Slave may stretch either phase; only the watchdog ends a wait
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
        check("hresp", 32'(hresp), 32'(HRESP_OKAY));
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input string what, input logic [31:0] a,
                          input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, ~exp, r);
        check(what, r, exp);
    endtask

    function automatic ubu_cycle_t mk(input logic [31:0] a, d, input logic p,
        f, w, input logic [1:0] s, input logic x);
        return '{valid: 1'b1, addr: a, data: d, periph: p, fetch: f,
                 write: w, size: s, external: x};
    endfunction

    function automatic logic hit_b(input logic [7:0] s, input ubu_cycle_t c);
        return s[SEL_CLASS_LSB + int'(c.periph)] &&
               s[SEL_FETCH_LSB + int'(!c.fetch)] &&
               s[SEL_RW_LSB + int'(c.write)] &&
               (s[1:0] == SIZE_ANY || s[1:0] == c.size);
    endfunction

    // Break request is a one-cycle pulse after the sampled cycle;
    // outputs are read at the edge after the one that launches them
    task automatic fire(input ubu_cycle_t c, input logic exp);
        send <= 1'b1;
        nxt  <= c;
        @(posedge hclk);
        send <= 1'b0;
        repeat (2) @(posedge hclk);
        check("break_req", 32'(break_req), 32'(exp));
        @(posedge hclk);
        check("break_req_end", 32'(break_req), 32'h0);
    endtask

    // Fire, check flags and interrupt, then clear flags keeping controls
    task automatic hit(input ubu_cycle_t c, input logic [15:0] fl, keep);
        fire(c, |fl);
        check("irq", 32'(user_break_irq), 32'(|fl));
        rd_chk("break_control", ADDR_BREAK_CONTROL, {16'h0, fl | keep});
        wr(ADDR_BREAK_CONTROL, {16'h0, keep});
    endtask

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic t_regs;
        rd_chk("ctrl_reset", ADDR_BREAK_CONTROL, 32'h0);
        rd_chk("sel_b_reset", ADDR_CYCLE_SELECT_B, 32'h0);
        wr(ADDR_BREAK_CONTROL, 32'hffffffff);
        rd_chk("ctrl_rw", ADDR_BREAK_CONTROL, 32'h341c);
        wr(ADDR_BREAK_CONTROL, 32'h0);
        wr(ADDR_CYCLE_SELECT_B, 32'hffffffff);
        rd_chk("sel_b_rw", ADDR_CYCLE_SELECT_B, 32'hff);
        wr(32'hffffff7c, 32'hffffffff);
        rd_chk("unmapped", 32'hffffff7c, 32'h0);
    endtask

    task automatic t_sweep;
        ubu_cycle_t c;
        logic       h;
        logic [15:0] fl;
        wr(ADDR_ADDRESS_MASK_B, 32'hffffffff);
        for (int k = 0; k < 4; k++) begin
            c = mk(32'h0, 32'h0, k[0], k[1], k[0] ^ k[1], 2'(k % 3 + 1), 1'b0);
            for (int i = 0; i < 256; i++) begin
                h = hit_b(8'(i), c);
                fl = {8'h0, h & ~c.periph, h & c.periph, 6'h0};
                wr(ADDR_CYCLE_SELECT_B, 32'(i));
                // every select code against four cycle kinds
                hit(c, fl, 16'h0);
            end
        end
    endtask

    task automatic t_chan_a;
        ubu_cycle_t ca;
        ca = mk(32'h1000, 32'h0, 1'b0, 1'b1, 1'b0, 2'h2, 1'b0);
        wr(ADDR_ADDRESS_A, 32'h1000);
        wr(ADDR_CYCLE_SELECT_A, 32'hfc);
        wr(ADDR_BREAK_CONTROL, 32'h0400);
        hit(ca, 16'h8000, 16'h0400);
        check("after_exec", 32'(break_after_exec), 32'h1);
        ca.periph = 1'b1;
        hit(ca, 16'h4000, 16'h0400);
        ca.addr = 32'h1004;
        hit(ca, 16'h0, 16'h0400);
        ca = mk(32'h1000, 32'h0, 1'b0, 1'b1, 1'b0, 2'h2, 1'b0);
        fire(ca, 1'b1);
        wr(ADDR_BREAK_CONTROL, 32'hc400);
        rd_chk("flag_kept", ADDR_BREAK_CONTROL, 32'h8400);
        wr(ADDR_BREAK_CONTROL, 32'h0);
        rd_chk("flag_clear", ADDR_BREAK_CONTROL, 32'h0);
        check("irq_clear", 32'(user_break_irq), 32'h0);
        hit(ca, 16'h8000, 16'h0);
        check("after_exec", 32'(break_after_exec), 32'h0);
    endtask

    task automatic t_chan_b;
        ubu_cycle_t cb;
        cb = mk(32'h20c4, 32'h0, 1'b0, 1'b0, 1'b1, 2'h2, 1'b0);
        wr(ADDR_ADDRESS_B, 32'h2000);
        wr(ADDR_ADDRESS_MASK_B, 32'hff);
        wr(ADDR_CYCLE_SELECT_B, 32'hfc);
        hit(cb, 16'h0080, 16'h0);
        cb.addr = 32'h21c4;
        hit(cb, 16'h0, 16'h0);
        cb.addr = 32'h2000;
        cb.data = 32'hcafe1234;
        wr(ADDR_DATA_B, 32'hcafe0000);
        wr(ADDR_DATA_MASK_B, 32'h0000ffff);
        wr(ADDR_BREAK_CONTROL, 32'h1008);
        hit(cb, 16'h0080, 16'h1008);
        cb.data = 32'hcaff0000;
        hit(cb, 16'h0, 16'h1008);
        wr(ADDR_BREAK_CONTROL, 32'h1000);
        hit(cb, 16'h0080, 16'h1000);
        wr(ADDR_BREAK_CONTROL, 32'h0008);
        hit(cb, 16'h0080, 16'h0008);
        cb.fetch    = 1'b1;
        cb.external = 1'b1;
        wr(ADDR_BREAK_CONTROL, 32'h0004);
        hit(cb, 16'h0, 16'h0004);
        wr(ADDR_BREAK_CONTROL, 32'h2004);
        hit(cb, 16'h0080, 16'h2004);
        check("after_exec_b", 32'(break_after_exec), 32'h1);
    endtask

    task automatic t_chain;
        ubu_cycle_t ca;
        ubu_cycle_t cb;
        ca = mk(32'h1000, 32'h0, 1'b0, 1'b1, 1'b0, 2'h2, 1'b0);
        cb = mk(32'h2000, 32'h0, 1'b0, 1'b0, 1'b0, 2'h2, 1'b0);
        wr(ADDR_BREAK_CONTROL, 32'h1010);
        hit(cb, 16'h0, 16'h1010);
        hit(ca, 16'h8000, 16'h1010);
        hit(cb, 16'h0080, 16'h1010);
        hit(cb, 16'h0, 16'h1010);
    endtask

    task automatic t_mid_reset;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("ctrl_reset2", ADDR_BREAK_CONTROL, 32'h0);
    endtask

    initial begin
        repeat (40000) @(posedge hclk);
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_sweep();
        t_chan_a();
        t_chan_b();
        t_chain();
        t_mid_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
